// [pkg/slc_params.svh]
// constants of the sleep mode controller
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
`define SLC_CONTROL_A_ADDR 8'h00
`define SLC_STATUS_ADDR 8'h04
`define SLC_STANDBY_ADDR 8'h08
`define SLC_CCLCFG_ADDR 8'h0c
`define SLC_SEN_BIT 0
`define SLC_SLEEP_MODE_SELECT_LSB 1
`define SLC_CONTROL_A_RESET 3'h0
`define SLC_SLEEP_MODE_SELECT_IDLE 2'h0
`define SLC_SLEEP_MODE_SELECT_STANDBY 2'h1
`define SLC_SLEEP_MODE_SELECT_PDOWN 2'h2
`define SLC_WAKE_CYCLES 4'h6
`define SLC_OSC_START_CYCLES 16'h0040
`define SLC_IRQ_N 8
`define SLC_IRQ_PIN 0
`define SLC_IRQ_TWI 1
`define SLC_IRQ_VLM 2
`define SLC_IRQ_CCL 3
`define SLC_IRQ_RTC 4
`define SLC_IRQ_PIT 5
`define SLC_IRQ_SOF 6
`define SLC_IRQ_TIMER 7
`define SLC_RSB_MAIN 0
`define SLC_RSB_RTC 1
`define SLC_RSB_CCL 2
`define SLC_RSB_ADC 3
`define SLC_RSB_TCA 4
`define SLC_RSB_TCB 5
`define SLC_RSB_N 6
`endif

// [pkg/slc_pkg.sv]
// types of the sleep mode controller
package slc_pkg;
  typedef enum logic [2:0] {
    SLC_ACTIVE = 3'b000,
    SLC_IDLE = 3'b001,
    SLC_STANDBY = 3'b010,
    SLC_PDOWN = 3'b011,
    SLC_WAKE = 3'b100
  } slc_state_t;
endpackage

// [rtl/slc_sync.sv]
// two-flop synchroniser for a vector of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module slc_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // slc_sync
`default_nettype wire

// [rtl/slc_top.sv]
// sleep mode controller: AHB-Lite registers, mode fsm, clock gating, wake logic
// Function
// - active plus idle, standby, power-down; enter from active
// - cpu halted while asleep
// - enabled wake interrupt resumes after sleep instruction
// - reset while asleep restarts from reset vector
// - state kept during sleep, no clears
// - no enabled interrupts: sleep until reset
// - idle stops cpu clock only, all wake
// - standby stops clocks lacking run-in-standby
// - power-down stops all high-frequency clocks
// - watchdog, brown-out oscillators always on
// - ccl, adc, timers gated per mode
// - rtc per mode; power-down periodic only
// - pin, twi match, vlm wake always
// - ccl wakes deep only when asynchronous
// - serial wakes idle; standby start-of-frame only
// - timer, adc, comparator wake idle, standby
// - mode codes idle 0, standby 1, down 2
// - wake takes six cycles, plus osc start if main osc stopped
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "slc_params.svh"
module slc_top #(
  parameter logic [15:0] OSC_START = `SLC_OSC_START_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_instr,
  input wire logic [`SLC_IRQ_N-1:0] irq_pending,
  input wire logic [`SLC_IRQ_N-1:0] irq_enabled,
  input wire logic other_irq,
  input wire logic other_irq_en,
  input wire logic global_irq_en,
  input wire logic reset_source,
  output logic cpu_halt,
  output logic cpu_wake,
  output logic sys_reset_req,
  output logic clk_cpu_en,
  output logic clk_main_en,
  output logic peripheral_clock_en,
  output logic clk_rtc_en,
  output logic rtc_pit_only,
  output logic clk_wdt_en,
  output logic clk_bod_en,
  output logic bod_sampled,
  output logic clk_ccl_en,
  output logic clk_adc_en,
  output logic clk_tca_en,
  output logic clk_tcb_en
);
  logic [2:0] control_a_r;
  logic [`SLC_RSB_N-1:0] run_in_standby_r;
  logic [3:0] ccl_cfg_r;
  slc_pkg::slc_state_t state_r;
  slc_pkg::slc_state_t state_nxt;
  logic [`SLC_IRQ_N-1:0] irq_s;
  logic rst_s;
  logic other_s;
  logic sleep_enable_bit;
  logic [1:0] sleep_mode_select;
  logic [`SLC_IRQ_N-1:0] wake_ok;
  logic wake_now;
  logic timer_start;
  logic timer_done;
  logic main_stopped_r;
  logic osc_stopped;
  logic ph_valid_r;
  logic ph_write_r;
  logic [7:0] ph_addr_r;
  logic [`SLC_IRQ_N:0] raw_in;
  logic [`SLC_IRQ_N:0] raw_s;
  logic [1:0] rst_pipe_r;
  slc_pkg::slc_state_t state_go;
  logic other_ok;

  assign sleep_enable_bit = control_a_r[`SLC_SEN_BIT];
  assign sleep_mode_select = control_a_r[`SLC_SLEEP_MODE_SELECT_LSB +: 2];

  // irq lines come from asynchronous domains (pin sensing, vlm)
  assign raw_in = {other_irq & other_irq_en, irq_pending & irq_enabled};
  slc_sync #(.W(`SLC_IRQ_N + 1)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(raw_in),
    .q(raw_s)
  );
  assign irq_s = raw_s[`SLC_IRQ_N-1:0];
  assign other_s = raw_s[`SLC_IRQ_N];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], reset_source};
    end
  end
  assign rst_s = rst_pipe_r[1];

  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (hready) begin
      ph_valid_r <= hsel && htrans[1];
      ph_write_r <= hwrite;
      ph_addr_r <= haddr[7:0];
    end
  end

  // registers untouched by sleep entry or exit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      control_a_r <= `SLC_CONTROL_A_RESET;
      run_in_standby_r <= '0;
      ccl_cfg_r <= 4'h0;
    end else if (ph_valid_r && ph_write_r) begin
      unique case (ph_addr_r)
        `SLC_CONTROL_A_ADDR: control_a_r <= hwdata[2:0];
        `SLC_STANDBY_ADDR: run_in_standby_r <= hwdata[`SLC_RSB_N-1:0];
        `SLC_CCLCFG_ADDR: ccl_cfg_r <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `SLC_CONTROL_A_ADDR: hrdata <= {29'h0, control_a_r};
        `SLC_STATUS_ADDR: hrdata <= {29'h0, state_r};
        `SLC_STANDBY_ADDR: hrdata <= {26'h0, run_in_standby_r};
        `SLC_CCLCFG_ADDR: hrdata <= {28'h0, ccl_cfg_r};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // wake qualification per source and mode
  always_comb begin
    wake_ok = '0;
    unique case (state_r)
      slc_pkg::SLC_IDLE: begin
        wake_ok = irq_s;
      end
      slc_pkg::SLC_STANDBY: begin
        wake_ok[`SLC_IRQ_PIN] = irq_s[`SLC_IRQ_PIN];
        wake_ok[`SLC_IRQ_TWI] = irq_s[`SLC_IRQ_TWI];
        wake_ok[`SLC_IRQ_VLM] = irq_s[`SLC_IRQ_VLM];
        wake_ok[`SLC_IRQ_CCL] = irq_s[`SLC_IRQ_CCL] & run_in_standby_r[`SLC_RSB_CCL]
          & (ccl_cfg_r == 4'h0);
        wake_ok[`SLC_IRQ_RTC] = irq_s[`SLC_IRQ_RTC] & run_in_standby_r[`SLC_RSB_RTC];
        wake_ok[`SLC_IRQ_PIT] = irq_s[`SLC_IRQ_PIT];
        wake_ok[`SLC_IRQ_SOF] = irq_s[`SLC_IRQ_SOF];
        // shared line; comparator has no run-in-standby bit of its own
        wake_ok[`SLC_IRQ_TIMER] = irq_s[`SLC_IRQ_TIMER] & (run_in_standby_r[`SLC_RSB_TCA]
          | run_in_standby_r[`SLC_RSB_TCB] | run_in_standby_r[`SLC_RSB_ADC]);
      end
      slc_pkg::SLC_PDOWN: begin
        // pin line is assumed async-sensed by software here
        wake_ok[`SLC_IRQ_PIN] = irq_s[`SLC_IRQ_PIN];
        wake_ok[`SLC_IRQ_TWI] = irq_s[`SLC_IRQ_TWI];
        wake_ok[`SLC_IRQ_VLM] = irq_s[`SLC_IRQ_VLM];
        wake_ok[`SLC_IRQ_CCL] = irq_s[`SLC_IRQ_CCL] & (ccl_cfg_r == 4'h0);
        wake_ok[`SLC_IRQ_PIT] = irq_s[`SLC_IRQ_PIT];
      end
      default: wake_ok = '0;
    endcase
  end

  // remaining sources only count in idle
  assign other_ok = other_s && (state_r == slc_pkg::SLC_IDLE);

  // without global enable nothing wakes; only reset helps
  assign wake_now = global_irq_en && ((|wake_ok) || other_ok);

  // also covers a wake already pending on the first sleeping cycle
  assign osc_stopped = main_stopped_r || (state_r == slc_pkg::SLC_PDOWN)
    || (state_r == slc_pkg::SLC_STANDBY && !run_in_standby_r[`SLC_RSB_MAIN]);
  assign timer_start = (state_r != slc_pkg::SLC_ACTIVE) && (state_r != slc_pkg::SLC_WAKE)
    && wake_now;

  slc_wake_timer #(.OSC_START(OSC_START)) u_wake (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(timer_start),
    .osc_stopped(osc_stopped),
    .done(timer_done)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      slc_pkg::SLC_ACTIVE: begin
        if (sleep_instr && sleep_enable_bit) begin
          unique case (sleep_mode_select)
            `SLC_SLEEP_MODE_SELECT_IDLE: state_nxt = slc_pkg::SLC_IDLE;
            `SLC_SLEEP_MODE_SELECT_STANDBY: state_nxt = slc_pkg::SLC_STANDBY;
            `SLC_SLEEP_MODE_SELECT_PDOWN: state_nxt = slc_pkg::SLC_PDOWN;
            default: state_nxt = slc_pkg::SLC_ACTIVE; // reserved code: stay awake
          endcase
        end
      end
      slc_pkg::SLC_IDLE, slc_pkg::SLC_STANDBY, slc_pkg::SLC_PDOWN: begin
        if (wake_now) begin
          state_nxt = slc_pkg::SLC_WAKE;
        end
      end
      slc_pkg::SLC_WAKE: begin
        if (timer_done) begin
          state_nxt = slc_pkg::SLC_ACTIVE;
        end
      end
      default: state_nxt = slc_pkg::SLC_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= slc_pkg::SLC_ACTIVE;
    end else if (rst_s) begin
      state_r <= slc_pkg::SLC_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // a reset abort reopens the gates at the same edge as the state,
  // so halt and reset request never overlap
  assign state_go = rst_s ? slc_pkg::SLC_ACTIVE : state_nxt;

  // remember whether main clock was off, for restart delay
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      main_stopped_r <= 1'b0;
    end else if (state_r == slc_pkg::SLC_ACTIVE) begin
      main_stopped_r <= 1'b0;
    end else if (state_r == slc_pkg::SLC_PDOWN
      || (state_r == slc_pkg::SLC_STANDBY && !run_in_standby_r[`SLC_RSB_MAIN])) begin
      main_stopped_r <= 1'b1;
    end
  end

  // reset while asleep is passed on as a device reset request
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= rst_s && (state_r != slc_pkg::SLC_ACTIVE);
    end
  end

  // gating outputs registered to keep them glitch free
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cpu_halt <= 1'b0;
      cpu_wake <= 1'b0;
      clk_cpu_en <= 1'b1;
      clk_wdt_en <= 1'b1;
      clk_bod_en <= 1'b1;
      bod_sampled <= 1'b0;
    end else begin
      // cpu stays gated through the whole wake delay
      cpu_halt <= state_go != slc_pkg::SLC_ACTIVE;
      cpu_wake <= state_r == slc_pkg::SLC_WAKE && timer_done;
      clk_cpu_en <= state_go == slc_pkg::SLC_ACTIVE;
      clk_wdt_en <= 1'b1;
      clk_bod_en <= 1'b1;
      bod_sampled <= state_go != slc_pkg::SLC_ACTIVE;
    end
  end

  // peripheral and clock source gates per mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clk_main_en <= 1'b1;
      peripheral_clock_en <= 1'b1;
      clk_rtc_en <= 1'b1;
      rtc_pit_only <= 1'b0;
      clk_ccl_en <= 1'b1;
      clk_adc_en <= 1'b1;
      clk_tca_en <= 1'b1;
      clk_tcb_en <= 1'b1;
    end else begin
      unique case (state_go)
        slc_pkg::SLC_STANDBY: begin
          // main oscillator kept only on request
          clk_main_en <= run_in_standby_r[`SLC_RSB_MAIN];
          peripheral_clock_en <= 1'b0;
          clk_rtc_en <= run_in_standby_r[`SLC_RSB_RTC];
          rtc_pit_only <= 1'b0;
          clk_ccl_en <= run_in_standby_r[`SLC_RSB_CCL];
          clk_adc_en <= run_in_standby_r[`SLC_RSB_ADC];
          clk_tca_en <= run_in_standby_r[`SLC_RSB_TCA];
          clk_tcb_en <= run_in_standby_r[`SLC_RSB_TCB];
        end
        slc_pkg::SLC_PDOWN: begin
          // rtc clock stays for the periodic interrupt only
          clk_main_en <= 1'b0;
          peripheral_clock_en <= 1'b0;
          clk_rtc_en <= 1'b1;
          rtc_pit_only <= 1'b1;
          clk_ccl_en <= 1'b0;
          clk_adc_en <= 1'b0;
          clk_tca_en <= 1'b0;
          clk_tcb_en <= 1'b0;
        end
        default: begin
          // idle and waking keep every peripheral clock
          clk_main_en <= 1'b1;
          peripheral_clock_en <= 1'b1;
          clk_rtc_en <= 1'b1;
          rtc_pit_only <= 1'b0;
          clk_ccl_en <= 1'b1;
          clk_adc_en <= 1'b1;
          clk_tca_en <= 1'b1;
          clk_tcb_en <= 1'b1;
        end
      endcase
    end
  end
endmodule // slc_top
`default_nettype wire

// [rtl/slc_wake_timer.sv]
// wake-up delay counter: fixed cycles plus optional oscillator start
`timescale 1ns/1ps
`default_nettype none
`include "slc_params.svh"
module slc_wake_timer #(
  parameter logic [15:0] OSC_START = `SLC_OSC_START_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic osc_stopped,
  output logic done
);
  logic [16:0] cnt_r;
  logic run_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      // main clock restart time adds to the fixed six cycles
      cnt_r <= {13'h0, `SLC_WAKE_CYCLES} + (osc_stopped ? {1'b0, OSC_START} : 17'h0) - 17'h1;
      run_r <= 1'b1;
    end else if (run_r && cnt_r != 17'h0) begin
      cnt_r <= cnt_r - 17'h1;
    end else begin
      run_r <= 1'b0;
    end
  end
  assign done = run_r && (cnt_r == 17'h0);
endmodule // slc_wake_timer
`default_nettype wire

// [verif/slc_cpu_model.sv]
// cpu core and interrupt source model
`timescale 1ns/1ps
`default_nettype none
module slc_cpu_model (
  input wire logic clk_sys,
  input wire logic cpu_wake,
  output logic sleep_instr,
  output logic [7:0] irq_pending,
  output logic other_irq
);
  initial begin
    sleep_instr = 1'b0;
    irq_pending = 8'h00;
    other_irq = 1'b0;
  end
  // handler runs on wake and retires its request
  always @(posedge clk_sys) begin
    if (cpu_wake) begin
      irq_pending <= 8'h00;
      other_irq <= 1'b0;
    end
  end
  // control_a is written by the bench before this
  task automatic sleep_now();
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
  endtask
  // pins treated as async sensed, so pin wakes power-down
  task automatic raise(input int i, input logic oth);
    @(posedge clk_sys);
    if (oth) begin
      other_irq <= 1'b1;
    end else begin
      irq_pending[i] <= 1'b1;
    end
  endtask
endmodule // slc_cpu_model
`default_nettype wire

// [verif/slc_top_props.sv]
// assertion checker bound to the sleep mode controller top
`timescale 1ns/1ps
`default_nettype none
module slc_top_props #(
  parameter logic [15:0] OSC_START = 16'h0040
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sleep_instr,
  input wire logic cpu_halt,
  input wire logic cpu_wake,
  input wire logic sys_reset_req,
  input wire logic clk_cpu_en,
  input wire logic clk_main_en,
  input wire logic peripheral_clock_en,
  input wire logic clk_rtc_en,
  input wire logic rtc_pit_only,
  input wire logic clk_wdt_en,
  input wire logic clk_bod_en,
  input wire logic clk_ccl_en,
  input wire logic clk_adc_en,
  input wire logic clk_tca_en,
  input wire logic clk_tcb_en
);
  logic [15:0] halt_cnt_r;
  // consecutive halted cycles, cleared on leaving sleep
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      halt_cnt_r <= 16'h0000;
    end else begin
      halt_cnt_r <= cpu_halt ? halt_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_HALT_CAUSE: assert property ($rose(cpu_halt) |-> $past(sleep_instr))
    else $error("halt without sleep instruction");
  AST_CPU_CLK: assert property (clk_cpu_en == !cpu_halt)
    else $error("cpu clock not tied to halt");
  AST_OSC_ON: assert property (clk_wdt_en && clk_bod_en)
    else $error("watchdog or brown-out clock stopped");
  AST_WAKE_PULSE: assert property (cpu_wake |-> !cpu_halt && $past(cpu_halt) ##1 !cpu_wake)
    else $error("bad wake pulse");
  AST_WAKE_TIME: assert property (cpu_wake |-> halt_cnt_r >= 16'h0006)
    else $error("wake shorter than six cycles");
  AST_PDOWN_OFF: assert property (rtc_pit_only |-> !(clk_main_en || peripheral_clock_en || clk_ccl_en
    || clk_adc_en || clk_tca_en || clk_tcb_en))
    else $error("clock running in power-down");
  AST_ACTIVE_ON: assert property (!cpu_halt |-> clk_main_en && peripheral_clock_en && clk_rtc_en
    && clk_ccl_en && clk_adc_en && clk_tca_en && clk_tcb_en && !rtc_pit_only)
    else $error("clock gated while active");
  AST_RESET_REQ: assert property ($rose(sys_reset_req) |-> !cpu_halt && $past(cpu_halt, 2))
    else $error("reset request not from sleep");
  cover property (cpu_wake);
  cover property ($rose(rtc_pit_only));
  cover property ($rose(sys_reset_req));
endmodule // slc_top_props
bind slc_top slc_top_props #(.OSC_START(OSC_START)) slc_top_props_i (.clk_sys, .reset,
  .sleep_instr, .cpu_halt, .cpu_wake, .sys_reset_req, .clk_cpu_en, .clk_main_en, .peripheral_clock_en,
  .clk_rtc_en, .rtc_pit_only, .clk_wdt_en, .clk_bod_en, .clk_ccl_en, .clk_adc_en,
  .clk_tca_en, .clk_tcb_en);
`default_nettype wire

// [verif/sleep_mode_controller_test.sv]
// self-checking testbench of the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_test;
  localparam logic [15:0] OSC = 16'h0008;
  logic clk_sys, reset, hwrite, other_irq_en, global_irq_en, reset_source;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] irq_enabled, irq_pending;
  logic hreadyout, hresp, sleep_instr, other_irq, cpu_halt, cpu_wake, sys_reset_req;
  logic clk_cpu_en, clk_main_en, peripheral_clock_en, clk_rtc_en, rtc_pit_only, clk_wdt_en;
  logic clk_bod_en, bod_sampled, clk_ccl_en, clk_adc_en, clk_tca_en, clk_tcb_en;
  logic [5:0] rsb;
  int fail_count, num_checks, n, m;
  slc_top #(.OSC_START(OSC)) slc_top_i (.clk_sys, .reset, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sleep_instr,
    .irq_pending, .irq_enabled, .other_irq, .other_irq_en, .global_irq_en, .reset_source,
    .cpu_halt, .cpu_wake, .sys_reset_req, .clk_cpu_en, .clk_main_en, .peripheral_clock_en, .clk_rtc_en,
    .rtc_pit_only, .clk_wdt_en, .clk_bod_en, .bod_sampled, .clk_ccl_en, .clk_adc_en,
    .clk_tca_en, .clk_tcb_en);
  slc_cpu_model slc_cpu_model_i (.clk_sys, .cpu_wake, .sleep_instr, .irq_pending, .other_irq);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hready is sampled at each edge; the slave never stalls, but we still wait
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // {main, per, rtc, ccl, adc, tca, tcb, pit only, cpu}
  function automatic logic [31:0] gates(input int md, input logic [5:0] r);
    if (md == 0) return 32'h000001fc;
    if (md == 1) return {23'h0, r[0], 1'b0, r[1], r[2], r[3], r[4], r[5], 2'h0};
    return 32'h00000042;
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    void'($urandom(32'h98cb1610));
    {reset, htrans, haddr, hwrite, hsize, hwdata} = {1'b1, 2'h0, 32'h0, 1'b0, 3'h2, 32'h0};
    {irq_enabled, other_irq_en, global_irq_en, reset_source} = {8'hff, 3'b110};
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk(q, 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(q, 32'h0);
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, 32'h0, k ? 32'h7 : 32'h2);
      slc_cpu_model_i.sleep_now();
      repeat (3) @(posedge clk_sys);
      chk(32'(cpu_halt), 32'h0);
    end
    for (int k = 0; k < 9; k++) begin
      m = k % 3;
      rsb = 6'($urandom);
      ahb(1'b1, 32'h8, {26'h0, rsb});
      ahb(1'b1, 32'hc, 32'h0);
      ahb(1'b1, 32'h0, 32'(m * 2 + 1));
      slc_cpu_model_i.sleep_now();
      @(posedge clk_sys);
      #1;
      chk({23'h0, clk_main_en, peripheral_clock_en, clk_rtc_en, clk_ccl_en, clk_adc_en,
        clk_tca_en, clk_tcb_en, rtc_pit_only, clk_cpu_en}, gates(m, rsb));
      ahb(1'b0, 32'h4, 32'h0);
      chk(q, 32'(m + 1));
      if (m != 0) begin
        slc_cpu_model_i.raise(0, 1'b1);
        repeat (12) @(posedge clk_sys);
        chk(32'(cpu_halt), 32'h1);
      end
      slc_cpu_model_i.raise(int'($urandom_range(2)), 1'b0);
      n = 0;
      while (cpu_wake !== 1'b1 && n < 300) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk(32'(n), 32'(9 + ((m == 2 || (m == 1 && !rsb[0])) ? OSC : 0)));
    end
    ahb(1'b0, 32'h8, 32'h0);
    chk(q, {26'h0, rsb});
    ahb(1'b1, 32'h8, 32'h0);
    ahb(1'b1, 32'h0, 32'h3);
    slc_cpu_model_i.sleep_now();
    slc_cpu_model_i.raise(7, 1'b0);
    repeat (12) @(posedge clk_sys);
    chk(32'(cpu_halt), 32'h1);
    slc_cpu_model_i.raise(6, 1'b0);
    repeat (20) @(posedge clk_sys);
    chk(32'(cpu_halt), 32'h0);
    global_irq_en <= 1'b0;
    ahb(1'b1, 32'h0, 32'h1);
    slc_cpu_model_i.sleep_now();
    slc_cpu_model_i.raise(0, 1'b0);
    repeat (12) @(posedge clk_sys);
    chk(32'(cpu_halt), 32'h1);
    reset_source <= 1'b1;
    n = 0;
    while (sys_reset_req !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({sys_reset_req, cpu_halt}, 32'h2);
    reset <= 1'b1;
    reset_source <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk(q, 32'h0);
    results();
  end
endmodule // sleep_mode_controller_test
`default_nettype wire
